// >>> design/phy_led_and_tx_options.sv
// Status indicator selection, stretch timing, symbol error mapping and transmit options
//
// Overview of operation
// - Third source field bits 7:4 picks indicator source; resets to receive (0010).
// - Codes 1000..1011 give steady on, steady off, fast blink, slow blink.
// - 1100 link+receive, 1101 link+activity, 1110 duplex+collision; 0110, 1111 unused.
// - Link combined modes: solid on while link up, toggle on each event.
// - Duplex+collision: solid on when full duplex, toggle on each collision.
// - Combined modes always stretch events, whatever the stretch-enable bit says.
// - Period field bits 3:2: 30, 60, 100 ms; 11 reserved; resets 00.
// - Bit 1 enables stretching on all indicators; clear shows raw events; resets 1.
// - Symbol-fault map bit drives symbol error onto receive error; resets 0.
// - Transmit low-power bit drives the transmit low-power output; resets 0.
// - Edge-rate field 11:10 resets from the strap pins; software may overwrite.
// - First and second source fields share encoding; reset to speed and link.
`timescale 1ns/1ps
module phy_led_and_tx_options
  import phy_indicator_pkg::*;
#(
  parameter int STRETCH_30 = STRETCH_30_CYC,
  parameter int STRETCH_60 = STRETCH_60_CYC,
  parameter int STRETCH_100 = STRETCH_100_CYC,
  parameter int BLINK_BASE = BLINK_BASE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Management register access
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // Line status and receive path
  input wire link_status_t status,
  input wire logic symbol_error,
  input wire logic rx_err_in,
  output logic rxer,
  // Strap pins and transmitter controls
  input wire logic [1:0] transmit_edge_rate_strap,
  output logic tx_low_power,
  output logic [1:0] tx_edge_rate,
  output logic mii_drive_strong,
  // Indicator outputs, high means lit
  output logic first_indicator_on,
  output logic second_indicator_on,
  output logic third_indicator_on
);

  logic [15:0] indicator_config_q;
  logic [15:0] digital_option_config_q;
  logic [15:0] transmit_control_q;
  logic strap_done_q;
  logic [15:0] rdata_d;
  logic [CNT_W-1:0] period_cyc;
  logic [CNT_W-1:0] base_cnt_q;
  logic base_tick;
  logic blink_fast_q;
  logic blink_slow_q;
  logic [1:0] slow_div_q;
  logic stretch_en;

  // Indicator configuration register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      indicator_config_q <= INDICATOR_CONFIG_RESET;
    end else if (reg_we && reg_addr == ADDR_INDICATOR_CONFIG) begin
      indicator_config_q <= reg_wdata;
    end
  end

  // Digital option register, reserved bits stay zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      digital_option_config_q <= DIGITAL_OPTION_RESET;
    end else if (reg_we && reg_addr == ADDR_DIGITAL_OPTION_CONFIG) begin
      digital_option_config_q <= reg_wdata & DIGITAL_OPTION_WMASK;
    end
  end

  // Transmit control register; edge rate loads from the straps just after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transmit_control_q <= TRANSMIT_CONTROL_RESET;
    end else if (!strap_done_q) begin
      transmit_control_q[EDGE_RATE_LSB +: 2] <= transmit_edge_rate_strap;
    end else if (reg_we && reg_addr == ADDR_TRANSMIT_CONTROL) begin
      transmit_control_q <= reg_wdata;
    end
  end

  // Strap capture happens once, on the first edge after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
    end
  end

  // Read data mux, unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ADDR_INDICATOR_CONFIG: rdata_d = indicator_config_q;
      ADDR_DIGITAL_OPTION_CONFIG: rdata_d = digital_option_config_q;
      ADDR_TRANSMIT_CONTROL: rdata_d = transmit_control_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // Read data is held until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_re) begin
      reg_rdata <= rdata_d;
    end
  end

  // Option outputs
  assign rxer = digital_option_config_q[SYMBOL_MAP_BIT] ? symbol_error : rx_err_in;
  assign tx_low_power = transmit_control_q[TX_LOW_POWER_BIT];
  assign tx_edge_rate = transmit_control_q[EDGE_RATE_LSB +: 2];
  assign mii_drive_strong = digital_option_config_q[DRIVE_STRENGTH_BIT];
  assign stretch_en = indicator_config_q[STRETCH_EN_BIT];

  // Stretch length select; reserved code falls back to the shortest period
  always_comb begin
    case (indicator_config_q[WIDEN_PERIOD_LSB +: 2])
      WIDEN_30: period_cyc = CNT_W'(STRETCH_30);
      WIDEN_60: period_cyc = CNT_W'(STRETCH_60);
      WIDEN_100: period_cyc = CNT_W'(STRETCH_100);
      default: period_cyc = CNT_W'(STRETCH_30);
    endcase
  end

  // Shared blink time base
  assign base_tick = (base_cnt_q == CNT_W'(BLINK_BASE - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_q <= '0;
    end else if (base_tick) begin
      base_cnt_q <= '0;
    end else begin
      base_cnt_q <= base_cnt_q + CNT_W'(1);
    end
  end

  // Fast blink toggles every tick, slow blink every fourth tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blink_fast_q <= 1'b0;
      blink_slow_q <= 1'b0;
      slow_div_q <= 2'h0;
    end else if (base_tick) begin
      blink_fast_q <= ~blink_fast_q;
      slow_div_q <= slow_div_q + 2'h1;
      if (slow_div_q == SLOW_DIV_LAST) begin
        blink_slow_q <= ~blink_slow_q;
      end
    end
  end

  // Three indicator drivers, one per source field
  indicator_drive u_first (
    .clock(clock),
    .rst_n(rst_n),
    .source(indicator_config_q[FIRST_SRC_LSB +: 4]),
    .stretch_en(stretch_en),
    .period_cyc(period_cyc),
    .status(status),
    .blink_fast(blink_fast_q),
    .blink_slow(blink_slow_q),
    .led_on(first_indicator_on)
  );

  indicator_drive u_second (
    .clock(clock),
    .rst_n(rst_n),
    .source(indicator_config_q[SECOND_SRC_LSB +: 4]),
    .stretch_en(stretch_en),
    .period_cyc(period_cyc),
    .status(status),
    .blink_fast(blink_fast_q),
    .blink_slow(blink_slow_q),
    .led_on(second_indicator_on)
  );

  indicator_drive u_third (
    .clock(clock),
    .rst_n(rst_n),
    .source(indicator_config_q[THIRD_SRC_LSB +: 4]),
    .stretch_en(stretch_en),
    .period_cyc(period_cyc),
    .status(status),
    .blink_fast(blink_fast_q),
    .blink_slow(blink_slow_q),
    .led_on(third_indicator_on)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence write_led_cfg;
    reg_we && reg_addr == ADDR_INDICATOR_CONFIG && strap_done_q;
  endsequence

  a_third_src_read: assert property ((reg_re && reg_addr == ADDR_INDICATOR_CONFIG)
      |=> (reg_rdata[THIRD_SRC_LSB +: 4] == $past(indicator_config_q[THIRD_SRC_LSB +: 4])))
    else $error("third source field read back wrong");
  a_period_sel: assert property (
      (indicator_config_q[WIDEN_PERIOD_LSB +: 2] == WIDEN_100)
      |-> (period_cyc == CNT_W'(STRETCH_100)))
    else $error("stretch period select wrong");
  a_symbol_map: assert property (digital_option_config_q[SYMBOL_MAP_BIT]
      && symbol_error |-> rxer)
    else $error("symbol error not mapped to receive error");
  a_low_power: assert property ((reg_we && reg_addr == ADDR_TRANSMIT_CONTROL)
      && strap_done_q |=> (tx_low_power == $past(reg_wdata[TX_LOW_POWER_BIT])))
    else $error("transmit low power did not follow write");
  a_strap_load: assert property ($rose(strap_done_q)
      |-> (tx_edge_rate == $past(transmit_edge_rate_strap)))
    else $error("edge rate not loaded from straps");
  // Written value lands, then stays unless the next cycle writes again
  a_led_cfg_write: assert property (write_led_cfg
      |=> (indicator_config_q == $past(reg_wdata))
      ##1 ((indicator_config_q == $past(reg_wdata, 2))
      || $past(reg_we && reg_addr == ADDR_INDICATOR_CONFIG)))
    else $error("indicator configuration write lost");

endmodule

// >>> design/phy_indicator_pkg.sv
// Shared constants and types for the status-indicator and transmit option block
package phy_indicator_pkg;

  // Clock rate and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // Management register addresses
  localparam logic [4:0] ADDR_INDICATOR_CONFIG = 5'h14;
  localparam logic [4:0] ADDR_DIGITAL_OPTION_CONFIG = 5'h1a;
  localparam logic [4:0] ADDR_TRANSMIT_CONTROL = 5'h1e;

  // Indicator configuration fields
  localparam int FIRST_SRC_LSB = 12;
  localparam int SECOND_SRC_LSB = 8;
  localparam int THIRD_SRC_LSB = 4;
  localparam int WIDEN_PERIOD_LSB = 2;
  localparam int STRETCH_EN_BIT = 1;
  localparam logic [15:0] INDICATOR_CONFIG_RESET = 16'h0422;

  // Digital option configuration fields (only these bits are writable)
  localparam int DRIVE_STRENGTH_BIT = 11;
  localparam int SYMBOL_MAP_BIT = 9;
  localparam logic [15:0] DIGITAL_OPTION_WMASK = 16'h0a00;
  localparam logic [15:0] DIGITAL_OPTION_RESET = 16'h0000;

  // Transmit control fields
  localparam int TX_LOW_POWER_BIT = 12;
  localparam int EDGE_RATE_LSB = 10;
  localparam logic [15:0] TRANSMIT_CONTROL_RESET = 16'h0000;

  // Indicator source codes
  localparam logic [3:0] SRC_SPEED = 4'h0;
  localparam logic [3:0] SRC_TX = 4'h1;
  localparam logic [3:0] SRC_RX = 4'h2;
  localparam logic [3:0] SRC_COL = 4'h3;
  localparam logic [3:0] SRC_LINK = 4'h4;
  localparam logic [3:0] SRC_DUPLEX = 4'h5;
  localparam logic [3:0] SRC_UNUSED_A = 4'h6;
  localparam logic [3:0] SRC_ACTIVITY = 4'h7;
  localparam logic [3:0] SRC_ON = 4'h8;
  localparam logic [3:0] SRC_OFF = 4'h9;
  localparam logic [3:0] SRC_BLINK_FAST = 4'ha;
  localparam logic [3:0] SRC_BLINK_SLOW = 4'hb;
  localparam logic [3:0] SRC_LINK_RX = 4'hc;
  localparam logic [3:0] SRC_LINK_ACT = 4'hd;
  localparam logic [3:0] SRC_DUP_COL = 4'he;
  localparam logic [3:0] SRC_UNUSED_B = 4'hf;

  // Stretch period codes and times
  localparam logic [1:0] WIDEN_30 = 2'h0;
  localparam logic [1:0] WIDEN_60 = 2'h1;
  localparam logic [1:0] WIDEN_100 = 2'h2;
  localparam int STRETCH_30_MS = 30;
  localparam int STRETCH_60_MS = 60;
  localparam int STRETCH_100_MS = 100;
  localparam int STRETCH_30_CYC = STRETCH_30_MS * CYC_PER_MS;
  localparam int STRETCH_60_CYC = STRETCH_60_MS * CYC_PER_MS;
  localparam int STRETCH_100_CYC = STRETCH_100_MS * CYC_PER_MS;

  // Blink base: fast rate toggles each base tick, slow rate every SLOW_DIV ticks
  localparam int BLINK_BASE_MS = 100;
  localparam int BLINK_BASE_CYC = BLINK_BASE_MS * CYC_PER_MS;
  localparam logic [1:0] SLOW_DIV_LAST = 2'h3;

  // Counter width, wide enough for the longest period
  localparam int CNT_W = 22;

  // Line status seen by the indicators
  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic full_duplex;
    logic tx_act;
    logic rx_act;
    logic col;
  } link_status_t;

endpackage

// >>> design/indicator_drive.sv
// One indicator output: source select, event stretch and combined modes
`timescale 1ns/1ps
module indicator_drive
  import phy_indicator_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration
  input wire logic [3:0] source,
  input wire logic stretch_en,
  input wire logic [CNT_W-1:0] period_cyc,
  // Status and blink rates
  input wire link_status_t status,
  input wire logic blink_fast,
  input wire logic blink_slow,
  // Indicator, high means lit
  output logic led_on
);

  logic combined;
  logic stretching;
  logic raw_ev;
  logic ev_str;
  logic led_d;
  logic [CNT_W-1:0] cnt_q;

  // Event selection for the chosen source
  always_comb begin
    combined = (source == SRC_LINK_RX) || (source == SRC_LINK_ACT) || (source == SRC_DUP_COL);
    stretching = stretch_en || combined;
    case (source)
      SRC_TX: raw_ev = status.tx_act;
      SRC_RX, SRC_LINK_RX: raw_ev = status.rx_act;
      SRC_COL, SRC_DUP_COL: raw_ev = status.col;
      SRC_ACTIVITY, SRC_LINK_ACT: raw_ev = status.tx_act | status.rx_act;
      default: raw_ev = 1'b0;
    endcase
  end

  // Stretch timer, restarted by every new event
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (stretching && raw_ev) begin
      cnt_q <= period_cyc - CNT_W'(1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  assign ev_str = stretching ? (raw_ev | (cnt_q != '0)) : raw_ev;

  // Indicator level per source code
  always_comb begin
    case (source)
      SRC_SPEED: led_d = status.speed_100;
      SRC_TX, SRC_RX, SRC_COL, SRC_ACTIVITY: led_d = ev_str;
      SRC_LINK: led_d = status.link_up;
      SRC_DUPLEX: led_d = status.full_duplex;
      SRC_ON: led_d = 1'b1;
      SRC_OFF: led_d = 1'b0;
      SRC_BLINK_FAST: led_d = blink_fast;
      SRC_BLINK_SLOW: led_d = blink_slow;
      SRC_LINK_RX, SRC_LINK_ACT: led_d = status.link_up ^ ev_str;
      SRC_DUP_COL: led_d = status.full_duplex ^ ev_str;
      default: led_d = 1'b0;
    endcase
  end

  // Registered indicator output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      led_on <= 1'b0;
    end else begin
      led_on <= led_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence combined_event;
    combined && raw_ev && !stretch_en;
  endsequence

  sequence event_in_stretch;
    stretching && raw_ev && (cnt_q != '0);
  endsequence

  a_test_on: assert property ((source == SRC_ON) |=> led_on)
    else $error("forced-on source did not light indicator");
  a_test_off: assert property ((source == SRC_OFF) |=> !led_on)
    else $error("forced-off source lit indicator");
  a_unused_dark: assert property ((source == SRC_UNUSED_A || source == SRC_UNUSED_B)
      |=> !led_on)
    else $error("unused source lit indicator");
  a_link_rx_toggle: assert property ((source == SRC_LINK_RX)
      && status.link_up && status.rx_act |=> !led_on)
    else $error("receive event did not toggle link indicator");
  a_dup_col_solid: assert property ((source == SRC_DUP_COL)
      && status.full_duplex && !ev_str |=> led_on)
    else $error("full duplex indicator not solid");
  a_combined_stretch: assert property (combined_event
      |=> (cnt_q == $past(period_cyc) - CNT_W'(1)))
    else $error("combined event not stretched");
  a_plain_event: assert property ((!stretch_en && source == SRC_TX)
      |=> (led_on == $past(status.tx_act)))
    else $error("unstretched transmit indicator wrong");
  a_stretch_restart: assert property (event_in_stretch
      |=> (cnt_q == $past(period_cyc) - CNT_W'(1)))
    else $error("stretch timer not restarted");

endmodule

// >>> sim/indicator_watch.sv
// Model of an indicator lamp that measures how long each lit or dark run lasts
`timescale 1ns/1ps
module indicator_watch (
  // Clock
  input wire logic clock,
  // Lamp drive, high means lit
  input wire logic led,
  // Length of the last completed run and number of changes seen
  output int gap,
  output int changes
);
  logic prev_q = 1'b0;
  int since_q = 0;

  // Count cycles between lamp changes, as an eye would see the blink rhythm
  always @(posedge clock) begin
    if (led !== prev_q) begin
      gap <= since_q;
      since_q <= 1;
      changes <= changes + 1;
    end else begin
      since_q <= since_q + 1;
    end
    prev_q <= led;
  end

  initial begin
    gap = 0;
    changes = 0;
  end
endmodule

// >>> sim/phy_led_and_tx_options_test.sv
// Self-checking testbench for the indicator and transmit option block
`timescale 1ns/1ps
module phy_led_and_tx_options_test;
  import phy_indicator_pkg::*;
  localparam int P30 = 3;
  localparam int P60 = 6;
  localparam int P100 = 10;
  localparam int BB = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] reg_rdata;
  link_status_t status = '0;
  logic symbol_error = 1'b0;
  logic rx_err_in = 1'b0;
  logic rxer;
  logic [1:0] strap = 2'b00;
  logic tx_low_power;
  logic [1:0] tx_edge_rate;
  logic mii_drive_strong;
  wire [2:0] led;
  int gap;
  int changes;
  int err_count = 0;
  int compares = 0;
  logic [3:0] plain_codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
    4'hf};

  phy_led_and_tx_options #(.STRETCH_30(P30), .STRETCH_60(P60), .STRETCH_100(P100),
    .BLINK_BASE(BB)) phy_led_and_tx_options_i (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .status(status),
    .symbol_error(symbol_error), .rx_err_in(rx_err_in), .rxer(rxer),
    .transmit_edge_rate_strap(strap), .tx_low_power(tx_low_power),
    .tx_edge_rate(tx_edge_rate), .mii_drive_strong(mii_drive_strong),
    .first_indicator_on(led[2]), .second_indicator_on(led[1]), .third_indicator_on(led[0]));

  indicator_watch indicator_watch_i (.clock(clock), .led(led[0]), .gap(gap), .changes(changes));

  // Free-running 25 MHz clock
  initial begin
    forever #20 clock = ~clock;
  end

  // Expected lamp level for the uncombined, unstretched sources
  function automatic logic exp_plain(input logic [3:0] c, input link_status_t s);
    case (c)
      4'h0: return s.speed_100;
      4'h1: return s.tx_act;
      4'h2: return s.rx_act;
      4'h3: return s.col;
      4'h4: return s.link_up;
      4'h5: return s.full_duplex;
      4'h7: return s.rx_act | s.tx_act;
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic int exp_period(input logic [1:0] p);
    return (p == 2'h1) ? P60 : (p == 2'h2) ? P100 : P30;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    cyc(1);
    reg_we = 1'b0;
    // Idle edge so a following request never re-raises the strobe in this time step
    cyc(1);
  endtask

  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic s);
    chk16(what, {15'h0000, e}, {15'h0000, s});
  endtask

  task automatic chk_range(input string what, input int lo, input int hi, input int s);
    compares++;
    if (s < lo || s > hi) begin
      err_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, s);
    end
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_re = 1'b1;
    cyc(1);
    reg_re = 1'b0;
    chk16("register read", e, reg_rdata);
    cyc(1);
  endtask

  // One-cycle event on the masked status lines
  task automatic fire(input logic [5:0] m);
    status = link_status_t'(6'(status) | m);
    cyc(1);
    status = link_status_t'(6'(status) & ~m);
  endtask

  // Length of the run that an event causes on the third lamp
  task automatic pulse_len(input logic [5:0] m, input int extra, output int len);
    int c0;
    c0 = changes;
    fire(m);
    if (extra > 0) begin
      cyc(extra);
      fire(m);
    end
    for (int k = 0; k < 60 && changes < c0 + 2; k++) cyc(1);
    len = gap;
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #(40 * 6000);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    int len;
    int c0;
    logic [15:0] d;
    logic [3:0] c;
    void'($urandom(32'ha5e0));
    strap = 2'($urandom);
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    cyc(2);
    chk_rd(ADDR_INDICATOR_CONFIG, 16'h0422);
    chk_rd(ADDR_DIGITAL_OPTION_CONFIG, 16'h0000);
    chk_rd(ADDR_TRANSMIT_CONTROL, {4'h0, strap, 10'h000});
    chk16("strap edge rate", {14'h0000, strap}, {14'h0000, tx_edge_rate});
    wr(5'h15, 16'hffff);
    chk_rd(5'h15, 16'h0000);
    // Symbol error mapping on and off
    wr(ADDR_DIGITAL_OPTION_CONFIG, 16'hffff);
    chk_rd(ADDR_DIGITAL_OPTION_CONFIG, 16'h0a00);
    chk1("drive strength", 1'b1, mii_drive_strong);
    for (int i = 0; i < 16; i++) begin
      if (i == 8) wr(ADDR_DIGITAL_OPTION_CONFIG, 16'h0000);
      symbol_error = 1'($urandom);
      rx_err_in = 1'($urandom);
      cyc(1);
      chk1("receive error", (i < 8) ? symbol_error : rx_err_in, rxer);
    end
    chk1("drive strength", 1'b0, mii_drive_strong);
    // Transmit controls overwrite the strap value
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      d[12] = i[0];
      wr(ADDR_TRANSMIT_CONTROL, d);
      chk_rd(ADDR_TRANSMIT_CONTROL, d);
      chk1("low power", d[12], tx_low_power);
      chk16("edge rate", {14'h0000, d[11:10]}, {14'h0000, tx_edge_rate});
    end
    // Plain sources with stretching off, all three lamps
    for (int i = 0; i < 40; i++) begin
      c = plain_codes[$urandom_range(0, 10)];
      status = link_status_t'(6'($urandom));
      wr(ADDR_INDICATOR_CONFIG, {c, c, c, 4'h0});
      cyc(3);
      for (int j = 0; j < 3; j++) begin
        chk1("plain lamp", exp_plain(c, status), led[j]);
      end
    end
    status = '0;
    // Test blink rates
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_INDICATOR_CONFIG, {8'h04, (i == 0) ? 4'ha : 4'hb, 4'h0});
      c0 = changes;
      for (int k = 0; k < 100 && changes < c0 + 3; k++) cyc(1);
      chk_range("blink interval", (i + 1) ** 2 * BB, (i + 1) ** 2 * BB, gap);
    end
    // Stretched transmit events for every period code
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_INDICATOR_CONFIG, {12'h041, 2'(p), 2'b10});
      cyc(2);
      pulse_len(6'h04, 0, len);
      chk_range("stretch length", exp_period(2'(p)), exp_period(2'(p)) + 2, len);
    end
    wr(ADDR_INDICATOR_CONFIG, 16'h0412);
    cyc(2);
    pulse_len(6'h04, 1, len);
    chk_range("restarted stretch", P30 + 2, P30 + 4, len);
    // Combined modes with the stretch bit clear
    for (int i = 0; i < 3; i++) begin
      status = link_status_t'((i == 2) ? 6'h08 : 6'h10);
      wr(ADDR_INDICATOR_CONFIG, {8'h04, 4'hc + 4'(i), 4'h0});
      cyc(3);
      chk1("combined primary", 1'b1, led[0]);
      pulse_len((i == 0) ? 6'h02 : (i == 1) ? 6'h04 : 6'h01, 0, len);
      chk_range("combined toggle", P30, P30 + 2, len);
      chk1("combined restored", 1'b1, led[0]);
      status = '0;
      cyc(3);
      chk1("combined idle", 1'b0, led[0]);
    end
    wrap_up();
  end
endmodule
